// *** inc/opmode_consts.svh ***
// Offsets, field positions, reset values and counts of the mode controller
`ifndef OPMODE_CONSTS_SVH
`define OPMODE_CONSTS_SVH

// Register indexes; byte address is four times the index
`define PWR_CTRL_IDX      8'h87
`define P1_WAKE_IDX       8'h91
`define MODE_CFG_IDX      8'hA0
`define MODE_STAT_IDX     8'hA1
`define ADDR_OF(idx)      {22'h000000, idx, 2'h0}

// Power control fields
`define PWR_IDLE_BIT      0
`define PWR_STOP_BIT      1

// Mode configuration fields
`define CFG_XTAL_BIT      0
`define CFG_WDT_ON_BIT    1
`define CFG_ANALOG_BIT    2

// Mode status fields
`define STAT_MODE_LSB     0
`define STAT_WAKE_P0_BIT  4
`define STAT_WAKE_P1_BIT  5

// Reset values
`define P1_WAKE_RESET     8'h00
`define MODE_CFG_RESET    3'h0

// Warm-up counts in oscillator clocks
`define WARM_XTAL_TICKS   13'h0800
`define WARM_FRC_TICKS    13'h0040
`define WARM_SLOW_TICKS   13'h0005

`endif

// *** inc/opmode_pkg.sv ***
// Types shared by the operating mode and wake-up controller
package opmode_pkg;

	// Operating and warm-up states
	typedef enum logic [2:0] {
		MODE_NORMAL    = 3'b000,
		MODE_IDLE      = 3'b001,
		MODE_STOP      = 3'b010,
		MODE_WARM_HIGH = 3'b011,
		MODE_WARM_SLOW = 3'b100
	} mode_t;

	// Clock and function gates driven to the rest of the chip
	typedef struct packed {
		logic cpu_run;
		logic high_osc_run;
		logic slow_rc_run;
		logic periph_en;
		logic analog_en;
		logic irq_en;
	} clk_gate_t;

	// Port pins sampled for wake-up
	typedef struct packed {
		logic [7:0] port0;
		logic [7:0] port1;
	} wake_pins_t;

	// Whole state of the controller
	typedef struct packed {
		mode_t      mode;
		logic       idle_bit;
		logic       stop_bit;
		logic [7:0] p1_wake_en;
		logic       xtal_sel;
		logic       wdt_always;
		logic       analog_req;
		logic [1:0] wake_flag;
		logic [12:0] cnt;
		wake_pins_t pin_s1;
		wake_pins_t pin_s2;
		wake_pins_t pin_prev;
		logic [2:0] hosc;
		logic [2:0] lrc;
		clk_gate_t  gates;
		logic [1:0] wake_irq;
		logic       pready;
		logic [31:0] prdata;
		logic       pslverr;
	} state_t;

endpackage : opmode_pkg

// *** src/operating_mode_wake_controller.sv ***
// Operating mode, wake-up and oscillator warm-up controller with APB access
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "opmode_consts.svh"

// What this block does
// - Three modes: normal, idle, stop
// - After reset start in normal mode
// - Normal: CPU runs, both oscillators run
// - Writing stop bit enters stop mode
// - Stop bit clears itself after stop wake
// - Writing idle bit enters idle mode
// - Idle bit clears itself after idle wake
// - Stop halts oscillators; slow RC per watchdog
// - Stop disables functions except comparator, op-amp
// - Stop keeps all registers and state
// - Idle halts CPU, system clock keeps running
// - Stop left only by port change, reset
// - Idle left by port change or interrupt
// - Port 0 pins always wake
// - Port 1 pins wake only when enabled
// - Rising or falling change both wake
// - Every wake returns to normal mode
// - Wake sets matching interrupt request flag
// - Crystal wake: 2048 high plus 5 slow
// - Fast RC wake: 64 high plus 5 slow
// - Power control: idle bit0, stop bit1
// - Interrupt enabled needs source and global enable
module operating_mode_wake_controller (
	// APB slave
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [31:0]            paddr,
	input  wire logic [31:0]            pwdata,
	output logic                        pready,
	output logic [31:0]                 prdata,
	output logic                        pslverr,
	// Port pins and oscillator toggles, asynchronous
	input  wire opmode_pkg::wake_pins_t pins,
	input  wire logic                   high_osc_toggle,
	input  wire logic                   slow_rc_toggle,
	// Interrupt controller, same clock
	input  wire logic [15:0]            irq_request,
	input  wire logic [15:0]            irq_source_enable,
	input  wire logic                   global_irq_enable,
	// Gates and wake requests
	output opmode_pkg::clk_gate_t       gates,
	output logic [2:0]                  mode_now,
	output logic                        wake_irq_port0,
	output logic                        wake_irq_port1
);
	import opmode_pkg::*;

	// ********************************************************
	// Functions
	// ********************************************************

	// Gate settings per mode; warm-up keeps the CPU held
	function automatic clk_gate_t gates_for(input mode_t m,
		input logic wdt_on, input logic analog);
		clk_gate_t g;
		g = '0;
		unique case (m)
			MODE_NORMAL: begin
				g = '1;
			end
			MODE_IDLE: begin
				g = '1;
				g.cpu_run = 1'b0;
			end
			MODE_STOP: begin
				g.slow_rc_run = wdt_on;
				g.analog_en   = analog;
			end
			MODE_WARM_HIGH: begin
				g.high_osc_run = 1'b1;
				g.slow_rc_run  = 1'b1;
				g.analog_en    = analog;
			end
			MODE_WARM_SLOW: begin
				g.high_osc_run = 1'b1;
				g.slow_rc_run  = 1'b1;
				g.analog_en    = analog;
			end
			default: begin
				g = '0;
			end
		endcase
		return g;
	endfunction : gates_for

	// Last tick of a warm-up phase
	function automatic logic last_tick(input logic [12:0] cnt,
		input logic [12:0] ticks);
		return (13'(cnt + 13'h0001) == ticks);
	endfunction : last_tick

	// ********************************************************
	// State and decode
	// ********************************************************

	state_t      s;
	state_t      next_s;
	logic        p0_change;
	logic        p1_change;
	logic        irq_wake;
	logic        high_tick;
	logic        slow_tick;
	logic [12:0] high_ticks;
	logic        wr_acc;
	logic [7:0]  idx;
	logic        idx_ok;

	// Pin changes compare the second sync stage with its history
	// A pin pulse shorter than one pclk period may be missed
	assign p0_change = |(s.pin_s2.port0 ^ s.pin_prev.port0);
	assign p1_change = |((s.pin_s2.port1 ^ s.pin_prev.port1)
		& s.p1_wake_en);
	assign irq_wake  = global_irq_enable
		& |(irq_request & irq_source_enable);
	// Each toggle of an oscillator line is one of its clocks
	assign high_tick = s.hosc[1] ^ s.hosc[0];
	assign slow_tick = s.lrc[1] ^ s.lrc[0];
	assign high_ticks = s.xtal_sel ? `WARM_XTAL_TICKS
		: `WARM_FRC_TICKS;
	// Write lands at the edge where the access completes
	assign wr_acc = psel & penable & s.pready & pwrite;
	assign idx    = paddr[9:2];
	assign idx_ok = (paddr[31:10] == 22'h000000)
		& (paddr[1:0] == 2'h0)
		& (idx == `PWR_CTRL_IDX | idx == `P1_WAKE_IDX
		| idx == `MODE_CFG_IDX | idx == `MODE_STAT_IDX);

	// ********************************************************
	// Next state
	// ********************************************************

	// Registers are only changed by bus writes and the mode machine,
	// so stop mode leaves every setting untouched
	always_comb begin
		next_s = s;
		next_s.pin_s1   = pins;
		next_s.pin_s2   = s.pin_s1;
		next_s.pin_prev = s.pin_s2;
		next_s.hosc     = {high_osc_toggle, s.hosc[2], s.hosc[1]};
		next_s.lrc      = {slow_rc_toggle, s.lrc[2], s.lrc[1]};
		next_s.wake_irq = 2'h0;

		// Bus writes
		if (wr_acc && idx_ok) begin
			unique case (idx)
				`PWR_CTRL_IDX: begin
					// Both bits at once favours the deeper mode
					next_s.stop_bit = pwdata[`PWR_STOP_BIT];
					next_s.idle_bit = pwdata[`PWR_IDLE_BIT]
						& ~pwdata[`PWR_STOP_BIT];
				end
				`P1_WAKE_IDX: begin
					next_s.p1_wake_en = pwdata[7:0];
				end
				`MODE_CFG_IDX: begin
					next_s.xtal_sel   = pwdata[`CFG_XTAL_BIT];
					next_s.wdt_always = pwdata[`CFG_WDT_ON_BIT];
					next_s.analog_req = pwdata[`CFG_ANALOG_BIT];
				end
				`MODE_STAT_IDX: begin
					next_s.wake_flag = s.wake_flag
						& ~pwdata[`STAT_WAKE_P1_BIT:`STAT_WAKE_P0_BIT];
				end
				default: begin
					next_s.wake_flag = s.wake_flag;
				end
			endcase
		end

		// Mode machine
		// The counter restarts in each warm phase; 13 bits hold 2048
		unique case (s.mode)
			MODE_NORMAL: begin
				next_s.cnt = 13'h0000;
				if (s.stop_bit) begin
					next_s.mode = MODE_STOP;
				end else if (s.idle_bit) begin
					next_s.mode = MODE_IDLE;
				end
			end
			MODE_IDLE: begin
				if (p0_change || p1_change || irq_wake) begin
					next_s.mode     = MODE_NORMAL;
					next_s.idle_bit = 1'b0;
					next_s.wake_irq = {p1_change, p0_change};
				end
			end
			MODE_STOP: begin
				// Interrupts are dead here, only pins may wake
				if (p0_change || p1_change) begin
					next_s.mode     = MODE_WARM_HIGH;
					next_s.cnt      = 13'h0000;
					next_s.wake_irq = {p1_change, p0_change};
				end
			end
			MODE_WARM_HIGH: begin
				if (high_tick) begin
					next_s.cnt = 13'(s.cnt + 13'h0001);
					if (last_tick(s.cnt, high_ticks)) begin
						next_s.mode = MODE_WARM_SLOW;
						next_s.cnt  = 13'h0000;
					end
				end
			end
			MODE_WARM_SLOW: begin
				if (slow_tick) begin
					next_s.cnt = 13'(s.cnt + 13'h0001);
					if (last_tick(s.cnt, `WARM_SLOW_TICKS)) begin
						next_s.mode     = MODE_NORMAL;
						next_s.stop_bit = 1'b0;
						next_s.idle_bit = 1'b0;
						next_s.cnt      = 13'h0000;
					end
				end
			end
			default: begin
				next_s.mode = MODE_NORMAL;
			end
		endcase

		// Sticky wake flags: a new wake beats a clear in the same cycle
		next_s.wake_flag = next_s.wake_flag | next_s.wake_irq;
		next_s.gates = gates_for(next_s.mode, next_s.wdt_always,
			next_s.analog_req);

		// APB answer one cycle into the access phase
		// Unmapped or unaligned offsets answer an error and write nothing
		next_s.pready  = psel & penable & ~s.pready;
		next_s.pslverr = psel & penable & ~s.pready & ~idx_ok;
		next_s.prdata  = 32'h00000000;
		if (psel && penable && !s.pready && !pwrite && idx_ok) begin
			unique case (idx)
				`PWR_CTRL_IDX: begin
					next_s.prdata[1:0] = {s.stop_bit, s.idle_bit};
				end
				`P1_WAKE_IDX: begin
					next_s.prdata[7:0] = s.p1_wake_en;
				end
				`MODE_CFG_IDX: begin
					next_s.prdata[2:0] = {s.analog_req, s.wdt_always,
						s.xtal_sel};
				end
				`MODE_STAT_IDX: begin
					next_s.prdata[2:0] = s.mode;
					next_s.prdata[5:4] = s.wake_flag;
				end
				default: begin
					next_s.prdata = 32'h00000000;
				end
			endcase
		end
	end

	// ********************************************************
	// State register
	// ********************************************************

	// Reset releases straight into normal mode with all gates open
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s            <= '0;
			s.mode       <= MODE_NORMAL;
			s.p1_wake_en <= `P1_WAKE_RESET;
			s.gates      <= '1;
		end else begin
			s <= next_s;
		end
	end

	// Outputs, all straight from the state register
	assign pready         = s.pready;
	assign prdata         = s.prdata;
	assign pslverr        = s.pslverr;
	assign gates          = s.gates;
	assign mode_now       = s.mode;
	assign wake_irq_port0 = s.wake_irq[0];
	assign wake_irq_port1 = s.wake_irq[1];

	// ********************************************************
	// Assertions
	// ********************************************************

	// All checks run on the bus clock and pause during reset
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	stop_entry_a: assert property (
		s.mode == MODE_NORMAL && s.stop_bit |=> s.mode == MODE_STOP)
		else $error("stop bit did not enter stop mode");
	idle_entry_a: assert property (
		s.mode == MODE_NORMAL && s.idle_bit && !s.stop_bit
		|=> s.mode == MODE_IDLE)
		else $error("idle bit did not enter idle mode");
	both_bits_a: assert property (
		wr_acc && idx == `PWR_CTRL_IDX && idx_ok && pwdata[1:0] == 2'h3
		|=> s.stop_bit && !s.idle_bit ##1 s.mode == MODE_STOP)
		else $error("stop and idle together did not pick stop");
	stop_clear_a: assert property (
		s.mode == MODE_NORMAL && $past(s.mode) == MODE_WARM_SLOW
		|-> !s.stop_bit)
		else $error("stop bit left set after wake");
	idle_exit_a: assert property (
		s.mode == MODE_IDLE && (p0_change || irq_wake)
		|=> s.mode == MODE_NORMAL && !s.idle_bit)
		else $error("idle mode not left on wake source");
	stop_osc_a: assert property (
		s.mode == MODE_STOP |-> !s.gates.high_osc_run
		&& !s.gates.cpu_run && s.gates.slow_rc_run == s.wdt_always)
		else $error("oscillator gates wrong in stop mode");
	stop_func_a: assert property (
		s.mode == MODE_STOP |-> !s.gates.periph_en && !s.gates.irq_en
		&& s.gates.analog_en == s.analog_req)
		else $error("function gates wrong in stop mode");
	stop_hold_a: assert property (
		s.mode == MODE_STOP && !p0_change && !p1_change
		|=> s.mode == MODE_STOP)
		else $error("stop mode left without pin change");
	warm_len_a: assert property (
		s.mode == MODE_WARM_SLOW && $past(s.mode) == MODE_WARM_HIGH
		|-> 13'($past(s.cnt) + 13'h0001) == $past(high_ticks))
		else $error("high clock warm-up count wrong");
	wake_flag_a: assert property (
		s.mode == MODE_STOP && p0_change
		|=> wake_irq_port0 && s.mode == MODE_WARM_HIGH)
		else $error("port 0 wake did not raise its request");

	// Gates per mode, warm-up hold and wake requests
	idle_gates_a: assert property (
		s.mode == MODE_IDLE |-> !s.gates.cpu_run
		&& s.gates.high_osc_run && s.gates.periph_en)
		else $error("gates wrong in idle mode");
	normal_gates_a: assert property (
		s.mode == MODE_NORMAL |-> s.gates == 6'h3F)
		else $error("gates not all open in normal mode");
	warm_hold_a: assert property (
		s.mode == MODE_WARM_HIGH || s.mode == MODE_WARM_SLOW
		|-> !s.gates.cpu_run && !s.gates.periph_en)
		else $error("CPU released before warm-up ended");
	slow_len_a: assert property (
		s.mode == MODE_NORMAL && $past(s.mode) == MODE_WARM_SLOW
		|-> 13'($past(s.cnt) + 13'h0001) == `WARM_SLOW_TICKS)
		else $error("slow clock warm-up count wrong");
	p1_flag_a: assert property (
		s.mode == MODE_STOP && p1_change && !p0_change
		|=> wake_irq_port1 && !wake_irq_port0)
		else $error("port 1 wake did not raise its request");
	stop_irq_a: assert property (
		s.mode == MODE_STOP && irq_wake
		|=> s.mode != MODE_NORMAL && s.mode != MODE_IDLE)
		else $error("interrupt left stop mode");
	flag_sticky_a: assert property (
		wake_irq_port0 |-> s.wake_flag[0])
		else $error("port 0 wake flag not set");

	// Main scenarios the bench should reach
	stop_wake_c: cover property (
		s.mode == MODE_WARM_SLOW ##1 s.mode == MODE_NORMAL);
	idle_irq_c: cover property (
		s.mode == MODE_IDLE && irq_wake && !p0_change && !p1_change);
	p1_wake_c: cover property (s.mode == MODE_STOP && p1_change);
	xtal_wake_c: cover property (
		s.mode == MODE_WARM_HIGH && s.xtal_sel && high_tick);
	both_bits_c: cover property (
		wr_acc && idx == `PWR_CTRL_IDX && pwdata[1:0] == 2'h3);

endmodule : operating_mode_wake_controller
`default_nettype wire

// *** tb/operating_mode_wake_controller_tb.sv ***
// Self-checking bench for the operating mode and wake-up controller
`timescale 1ns/1ps
`default_nettype none
`include "opmode_consts.svh"
module operating_mode_wake_controller_tb;
	import opmode_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, pe;
	logic [31:0] paddr, pwdata, prdata, rd;
	wake_pins_t  pins;
	logic        hot, srt, gie, wp0, wp1;
	logic [15:0] irq, irq_en;
	clk_gate_t   gates;
	logic [2:0]  mode_now;
	int          err_total, n_tests, n;

	operating_mode_wake_controller i_operating_mode_wake_controller (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .pins(pins),
		.high_osc_toggle(hot), .slow_rc_toggle(srt), .irq_request(irq),
		.irq_source_enable(irq_en), .global_irq_enable(gie),
		.gates(gates), .mode_now(mode_now), .wake_irq_port0(wp0),
		.wake_irq_port1(wp1));
	osc_model i_osc_model (.pclk(pclk), .gates(gates),
		.high_osc_toggle(hot), .slow_rc_toggle(srt));

	// ************************************************************
	// Clock and watchdog
	// ************************************************************
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	// Whole run needs about 4400 cycles; 30000 leaves margin
	initial begin
		#750000;
		err_total++;
		results();
	end

	// ************************************************************
	// Shared tasks
	// ************************************************************
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			err_total++;
			$display("mismatch %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task rng(input string nm, input int lo, input int hi);
		chk(nm, 32'h1, 32'(n >= lo && n <= hi));
	endtask : rng
	// One APB transfer; waits for pready, never assumes its latency
	task apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= `ADDR_OF(idx);
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		pe = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// The answer stands for one cycle only
		@(posedge pclk);
		chk("pready", 32'h0, 32'(pready));
	endtask : apb
	task wait_mode(input logic [2:0] m, input int lim);
		n = 0;
		while (mode_now !== m && n < lim) begin
			@(posedge pclk);
			n++;
		end
		chk("mode", 32'(m), 32'(mode_now));
	endtask : wait_mode

	// ************************************************************
	// Scenarios
	// ************************************************************
	task t_reset;
		chk("mode", 32'h0, 32'(mode_now));
		chk("gates", 32'h3F, 32'(gates));
		apb(1'b0, `PWR_CTRL_IDX, 32'h0);
		chk("pwr", 32'h0, rd);
		apb(1'b0, `P1_WAKE_IDX, 32'h0);
		chk("p1w", 32'h0, rd);
		apb(1'b0, 8'h00, 32'h0);
		chk("pslverr", 32'h1, 32'(pe));
	endtask : t_reset
	task t_idle_pin;
		apb(1'b1, `PWR_CTRL_IDX, 32'h1);
		wait_mode(3'h1, 10);
		chk("cpu", 32'h0, 32'(gates.cpu_run));
		chk("hosc", 32'h1, 32'(gates.high_osc_run));
		chk("per", 32'h1, 32'(gates.periph_en));
		pins.port0[3] <= 1'b1;
		wait_mode(3'h0, 10);
		chk("wake0", 32'h1, 32'(wp0));
		apb(1'b0, `PWR_CTRL_IDX, 32'h0);
		chk("pwr", 32'h0, rd);
	endtask : t_idle_pin
	task t_idle_irq;
		irq <= 16'h0004;
		irq_en <= 16'h0004;
		apb(1'b1, `PWR_CTRL_IDX, 32'h1);
		wait_mode(3'h1, 10);
		repeat (5) @(posedge pclk);
		chk("mode", 32'h1, 32'(mode_now));
		gie <= 1'b1;
		wait_mode(3'h0, 10);
		chk("wake0", 32'h0, 32'(wp0));
		irq <= 16'h0;
	endtask : t_idle_irq
	task t_stop_rc;
		apb(1'b1, `P1_WAKE_IDX, 32'h2);
		irq <= 16'h0004;
		apb(1'b1, `PWR_CTRL_IDX, 32'h3);
		wait_mode(3'h2, 10);
		chk("gates", 32'h0, 32'(gates));
		apb(1'b0, `PWR_CTRL_IDX, 32'h0);
		chk("pwr", 32'h2, rd);
		pins.port1[0] <= 1'b1;
		repeat (8) @(posedge pclk);
		chk("mode", 32'h2, 32'(mode_now));
		pins.port1[1] <= 1'b0;
		wait_mode(3'h3, 10);
		chk("wake1", 32'h1, 32'(wp1));
		wait_mode(3'h4, 200);
		rng("warm_high", 124, 136);
		wait_mode(3'h0, 60);
		rng("warm_slow", 16, 28);
		apb(1'b0, `PWR_CTRL_IDX, 32'h0);
		chk("pwr", 32'h0, rd);
		apb(1'b0, `P1_WAKE_IDX, 32'h0);
		chk("p1w", 32'h2, rd);
		irq <= 16'h0;
	endtask : t_stop_rc
	task t_stop_xtal;
		apb(1'b1, `MODE_CFG_IDX, 32'h7);
		apb(1'b1, `PWR_CTRL_IDX, 32'h2);
		wait_mode(3'h2, 10);
		chk("gates", 32'h0A, 32'(gates));
		pins.port0[7] <= 1'b1;
		wait_mode(3'h3, 10);
		wait_mode(3'h4, 4200);
		rng("warm_high", 4092, 4104);
		wait_mode(3'h0, 60);
		chk("gates", 32'h3F, 32'(gates));
		apb(1'b0, `MODE_STAT_IDX, 32'h0);
		chk("stat", 32'h30, rd);
		apb(1'b1, `MODE_STAT_IDX, 32'h10);
		apb(1'b0, `MODE_STAT_IDX, 32'h0);
		chk("stat", 32'h20, rd);
	endtask : t_stop_xtal

	task results;
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : results

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, gie} = 4'h0;
		paddr = 32'h0;
		pwdata = 32'h0;
		pins = '{port0: 8'h00, port1: 8'h02};
		irq = 16'h0;
		irq_en = 16'h0;
		err_total = 0;
		n_tests = 0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_idle_pin();
		t_idle_irq();
		t_stop_rc();
		t_stop_xtal();
		results();
	end
endmodule : operating_mode_wake_controller_tb
`default_nettype wire

// *** tb/osc_model.sv ***
// Oscillator model that runs each clock line only while its gate is open
`timescale 1ns/1ps
`default_nettype none
module osc_model (
	// Clock and gates from the controller
	input  wire logic                  pclk,
	input  wire opmode_pkg::clk_gate_t gates,
	// Oscillator lines, one level change per oscillator clock
	output logic                       high_osc_toggle,
	output logic                       slow_rc_toggle
);
	import opmode_pkg::*;
	logic [1:0] div;
	// ************************************************************
	// Toggle generation
	// ************************************************************
	// Fast line every 2 pclk, slow every 4; a stopped one stands still
	initial begin
		div = 2'h0;
		high_osc_toggle = 1'b0;
		slow_rc_toggle = 1'b0;
		forever begin
			@(posedge pclk);
			div <= div + 2'h1;
			if (gates.high_osc_run && div[0])
				high_osc_toggle <= ~high_osc_toggle;
			if (gates.slow_rc_run && div == 2'h3)
				slow_rc_toggle <= ~slow_rc_toggle;
		end
	end
endmodule : osc_model
`default_nettype wire
